// ==== design/bbm_pkg.sv ====
// Package for the base/bounds address mapper: register map, field layouts,
// segment offsets, reset values and the request/response carriers.
// Assumes one core clock shared by the pipeline and the register port.
package bbm_pkg;

	// Register offsets (byte addresses, one 32-bit word each)
	localparam logic [7:0] OFS_INSTR_BASE_OFFSET = 8'h00;
	localparam logic [7:0] OFS_ILIMIT = 8'h04;
	localparam logic [7:0] OFS_DATA_BASE_OFFSET = 8'h08;
	localparam logic [7:0] OFS_DLIMIT = 8'h0C;
	localparam logic [7:0] OFS_CACHE_POLICY_SELECT = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;
	localparam logic [7:0] OFS_MASK = 8'h18;
	localparam logic [7:0] OFS_FAULT = 8'h1C;

	// Field layouts
	localparam int PG_LSB = 12;
	localparam int SEG_LSB = 29;
	localparam int CACHE_POLICY_SELECT_W = 3;
	localparam int CACHE_POLICY_SELECT_N = 8;
	localparam int NEV = 4;
	localparam int EV_I_AERR = 0;
	localparam int EV_I_BERR = 1;
	localparam int EV_D_AERR = 2;
	localparam int EV_D_BERR = 3;

	// Top of the user segment, then window starts, each also the amount subtracted for its window
	localparam logic [31:0] USER_TOP = 32'h7FFF_FFFF;
	localparam logic [31:0] KCACHED_OFS = 32'h8000_0000;
	localparam logic [31:0] KUNCACHED_OFS = 32'hA000_0000;
	localparam logic [31:0] KUPPER_OFS = 32'hC000_0000;

	// Cache policy codes and reset values
	localparam logic [2:0] CACHE_POLICY_SELECT_UNCACHED = 3'h2;
	localparam logic [2:0] CACHE_POLICY_SELECT_CACHED = 3'h3;
	localparam logic [23:0] CACHE_POLICY_SELECT_RST = 24'h6D_36DB;
	localparam logic [19:0] BASE_RST = 20'h0_0000;
	localparam logic [18:0] LIMIT_RST = 19'h0_0000;
	localparam logic [NEV-1:0] EV_RST = 4'h0;

	typedef struct packed {
		logic valid;
		logic user;
		logic [63:0] addr;
	} bbm_req_t;

	typedef struct packed {
		logic valid;
		logic go;
		logic addr_err;
		logic bound_err;
		logic [2:0] cache_policy_select;
		logic [31:0] paddr;
		logic [31:0] fault;
	} bbm_rsp_t;

	// Picks the cache policy field for a segment index
	function automatic logic [2:0] cache_policy_select_field(input logic [23:0] cache_policy_select, input logic [2:0] seg);
		cache_policy_select_field = cache_policy_select[seg*CACHE_POLICY_SELECT_W +: CACHE_POLICY_SELECT_W];
	endfunction : cache_policy_select_field

endpackage : bbm_pkg

// ==== design/bbm_xlate.sv ====
// Combinational program-to-physical translation for one access stream.
// Assumes base, limit and policy come from registers of the same clock.
`timescale 1ns/1ps
module bbm_xlate import bbm_pkg::*; (
	input bbm_req_t req,
	input wire logic [19:0] base,
	input wire logic [18:0] limit,
	input wire logic [23:0] cache_policy_select,
	output bbm_rsp_t rsp
);
	logic [31:0] pa;
	logic [2:0] seg;

	// Upper word of the address is never looked at
	assign pa = req.addr[31:0];
	assign seg = pa[31:SEG_LSB];

	// Segment decode, window offsets and base/bounds check
	always_comb begin
		rsp = '0;
		rsp.valid = req.valid;
		rsp.cache_policy_select = cache_policy_select_field(cache_policy_select, seg);
		rsp.fault = pa;
		if (!pa[31]) begin
			// Same path in either mode
			if (pa[31:PG_LSB] > {1'b0, limit}) begin
				rsp.bound_err = 1'b1;
			end else begin
				rsp.paddr = {pa[31:PG_LSB] + base, pa[PG_LSB-1:0]};
			end
		end else if (req.user) begin
			rsp.addr_err = 1'b1;
		end else begin
			unique case (seg)
				3'b100: rsp.paddr = pa - KCACHED_OFS;
				3'b101: rsp.paddr = pa - KUNCACHED_OFS;
				default: rsp.paddr = pa - KUPPER_OFS;
			endcase
		end
		// An empty slot carries junk on its address, so it may raise no fault
		if (!req.valid) begin
			rsp.addr_err = 1'b0;
			rsp.bound_err = 1'b0;
		end
		// A failed check never reaches memory
		rsp.go = req.valid && !rsp.addr_err && !rsp.bound_err;
		if (!rsp.go) begin
			rsp.paddr = '0;
		end
	end

endmodule : bbm_xlate

// ==== design/bbm_mapper.sv ====
// Base/bounds address mapper: two translators, control registers,
// sticky fault status with interrupt, registered responses.
// Assumes requests come from pipeline logic on the same clock, no sync.
//
// What this block does
// - A user-mode address above the top of the user segment is not translated and raises an address error.
// - The low 2-Gbyte user segment is the only user-mode space and kernel mode reaches it with the same translation.
// - Kernel cached window addresses are kernel-only and map by subtracting its start address.
// - Kernel uncached window addresses are kernel-only and map by subtracting its start address.
// - Kernel upper window addresses are kernel-only and map by subtracting its start address.
// - Only the low 32 address bits count and the physical space is 4 Gbytes.
// - Fetches use the instruction base and limit, data uses the data pair, with one algorithm.
// - User-segment page bits 31:12 are compared against limit bits 30:12.
// - A user-segment address above the limit raises a bound error and yields no physical address.
// - In range, physical page is program page plus base page and the low 12 bits pass through.
// - Cache policy comes from the field picked by program address bits 31:29.
// - After reset the cached window is cacheable and the uncached window uncached, both changeable.
`timescale 1ns/1ps
module bbm_mapper import bbm_pkg::*; #(
	parameter int REG_AW = 8
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [REG_AW-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input bbm_req_t i_req,
	input bbm_req_t d_req,
	output bbm_rsp_t i_rsp,
	output bbm_rsp_t d_rsp,
	output logic irq
);
	// Refuse address widths below 6 or above 8 bits
	if (REG_AW < 6 || REG_AW > 8) begin : g_bad_aw
		$error("REG_AW must lie between 6 and 8");
	end

	logic [19:0] instr_base_offset_r, instr_base_offset_nxt, data_base_offset_r, data_base_offset_nxt;
	logic [18:0] ilimit_r, ilimit_nxt, dlimit_r, dlimit_nxt;
	logic [23:0] cache_policy_select_r, cache_policy_select_nxt;
	logic [NEV-1:0] status_r, status_nxt, mask_r, mask_nxt, ev;
	logic [31:0] fault_r, fault_nxt, rdata_r, rdata_nxt;
	logic irq_r, irq_nxt;
	bbm_rsp_t i_comb, d_comb, i_rsp_r, d_rsp_r;
	logic [7:0] ra;

	assign ra = 8'(reg_addr);

	// Same translator twice, each fed its own register pair
	bbm_xlate u_ixl (
		.req(i_req),
		.base(instr_base_offset_r),
		.limit(ilimit_r),
		.cache_policy_select(cache_policy_select_r),
		.rsp(i_comb)
	);

	bbm_xlate u_dxl (
		.req(d_req),
		.base(data_base_offset_r),
		.limit(dlimit_r),
		.cache_policy_select(cache_policy_select_r),
		.rsp(d_comb)
	);

	// Fault events from both streams
	assign ev = {d_comb.bound_err, d_comb.addr_err, i_comb.bound_err, i_comb.addr_err};

	// Register writes, sticky status and read-back
	always_comb begin
		instr_base_offset_nxt = instr_base_offset_r;
		ilimit_nxt = ilimit_r;
		data_base_offset_nxt = data_base_offset_r;
		dlimit_nxt = dlimit_r;
		cache_policy_select_nxt = cache_policy_select_r;
		mask_nxt = mask_r;
		status_nxt = status_r;
		fault_nxt = fault_r;
		rdata_nxt = 32'h0000_0000;
		if (reg_wr) begin
			unique case (ra)
				OFS_INSTR_BASE_OFFSET: instr_base_offset_nxt = reg_wdata[31:PG_LSB];
				OFS_ILIMIT: ilimit_nxt = reg_wdata[30:PG_LSB];
				OFS_DATA_BASE_OFFSET: data_base_offset_nxt = reg_wdata[31:PG_LSB];
				OFS_DLIMIT: dlimit_nxt = reg_wdata[30:PG_LSB];
				OFS_CACHE_POLICY_SELECT: cache_policy_select_nxt = reg_wdata[23:0];
				OFS_STATUS: status_nxt = status_r & ~reg_wdata[NEV-1:0];
				OFS_MASK: mask_nxt = reg_wdata[NEV-1:0];
				default: ;
			endcase
		end
		// New events win over a clear in the same cycle
		status_nxt = status_nxt | ev;
		// Data fault is the one kept when both streams fail together
		if (d_comb.addr_err || d_comb.bound_err) begin
			fault_nxt = d_comb.fault;
		end else if (i_comb.addr_err || i_comb.bound_err) begin
			fault_nxt = i_comb.fault;
		end
		if (reg_rd) begin
			unique case (ra)
				OFS_INSTR_BASE_OFFSET: rdata_nxt = {instr_base_offset_r, 12'h000};
				OFS_ILIMIT: rdata_nxt = {1'b0, ilimit_r, 12'h000};
				OFS_DATA_BASE_OFFSET: rdata_nxt = {data_base_offset_r, 12'h000};
				OFS_DLIMIT: rdata_nxt = {1'b0, dlimit_r, 12'h000};
				OFS_CACHE_POLICY_SELECT: rdata_nxt = {8'h00, cache_policy_select_r};
				OFS_STATUS: rdata_nxt = {28'h000_0000, status_r};
				OFS_MASK: rdata_nxt = {28'h000_0000, mask_r};
				OFS_FAULT: rdata_nxt = fault_r;
				default: rdata_nxt = 32'h0000_0000;
			endcase
		end
		irq_nxt = |(status_nxt & mask_nxt);
	end

	// Register group flops; policy reset makes the cached window cacheable
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			instr_base_offset_r <= BASE_RST;
			ilimit_r <= LIMIT_RST;
			data_base_offset_r <= BASE_RST;
			dlimit_r <= LIMIT_RST;
			cache_policy_select_r <= CACHE_POLICY_SELECT_RST;
			mask_r <= EV_RST;
			status_r <= EV_RST;
			fault_r <= 32'h0000_0000;
			rdata_r <= 32'h0000_0000;
			irq_r <= 1'b0;
		end else begin
			instr_base_offset_r <= instr_base_offset_nxt;
			ilimit_r <= ilimit_nxt;
			data_base_offset_r <= data_base_offset_nxt;
			dlimit_r <= dlimit_nxt;
			cache_policy_select_r <= cache_policy_select_nxt;
			mask_r <= mask_nxt;
			status_r <= status_nxt;
			fault_r <= fault_nxt;
			rdata_r <= rdata_nxt;
			irq_r <= irq_nxt;
		end
	end

	// Responses registered so every output leaves a flop; one cycle of latency
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			i_rsp_r <= '0;
			d_rsp_r <= '0;
		end else begin
			i_rsp_r <= i_comb;
			d_rsp_r <= d_comb;
		end
	end

	assign i_rsp = i_rsp_r;
	assign d_rsp = d_rsp_r;
	assign reg_rdata = rdata_r;
	assign irq = irq_r;

	// Helper: low only in the first cycle after reset release
	logic seen_r;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			seen_r <= 1'b0;
		end else begin
			seen_r <= 1'b1;
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	user_above_a: assert property (
		d_req.valid && d_req.user && d_req.addr[31]
		|=> d_rsp.addr_err && !d_rsp.go && !d_rsp.bound_err)
		else $error("user access above user segment not refused");

	kernel_user_seg_a: assert property (
		i_req.valid && !i_req.user && !i_req.addr[31]
		|=> !i_rsp.addr_err && (i_rsp.go != i_rsp.bound_err))
		else $error("kernel access to user segment mistranslated");

	kcached_map_a: assert property (
		d_req.valid && !d_req.user && d_req.addr[31:29] == 3'b100
		|=> d_rsp.go && d_rsp.paddr == {3'b000, $past(d_req.addr[28:0])})
		else $error("kernel cached window offset wrong");

	kuncached_map_a: assert property (
		i_req.valid && !i_req.user && i_req.addr[31:29] == 3'b101
		|=> i_rsp.go && i_rsp.paddr == {3'b000, $past(i_req.addr[28:0])})
		else $error("kernel uncached window offset wrong");

	kupper_map_a: assert property (
		d_req.valid && !d_req.user && d_req.addr[31:30] == 2'b11
		|=> d_rsp.go && d_rsp.paddr == {2'b00, $past(d_req.addr[29:0])})
		else $error("kernel upper window offset wrong");

	bound_check_a: assert property (
		d_req.valid && !d_req.addr[31] && d_req.addr[31:12] > {1'b0, dlimit_r}
		|=> d_rsp.bound_err && !d_rsp.go && d_rsp.paddr == 32'h0000_0000)
		else $error("out-of-range user access not refused");

	instr_sum_a: assert property (
		i_req.valid && !i_req.addr[31] && i_req.addr[31:12] <= {1'b0, ilimit_r}
		|=> i_rsp.go && i_rsp.paddr[11:0] == $past(i_req.addr[11:0])
		&& i_rsp.paddr[31:12] == $past(i_req.addr[31:12]) + $past(instr_base_offset_r))
		else $error("instruction user translation wrong");

	data_sum_a: assert property (
		d_req.valid && !d_req.addr[31] && d_req.addr[31:12] <= {1'b0, dlimit_r}
		|=> d_rsp.go && d_rsp.paddr[31:12] == $past(d_req.addr[31:12]) + $past(data_base_offset_r))
		else $error("data user translation wrong");

	policy_pick_a: assert property (
		i_req.valid |=> i_rsp.cache_policy_select == cache_policy_select_field($past(cache_policy_select_r), $past(i_req.addr[31:29])))
		else $error("cache policy field not selected by segment");

	policy_reset_a: assert property (
		!seen_r |-> cache_policy_select_field(cache_policy_select_r, 3'b100) == CACHE_POLICY_SELECT_CACHED
		&& cache_policy_select_field(cache_policy_select_r, 3'b101) == CACHE_POLICY_SELECT_UNCACHED)
		else $error("cache policy reset value wrong");

	fault_report_a: assert property (
		d_req.valid && d_req.user && d_req.addr[31]
		|=> d_rsp.fault == $past(d_req.addr[31:0]) && fault_r == d_rsp.fault)
		else $error("faulting address not reported");

	irq_follow_a: assert property (
		(|(status_r & mask_r)) |-> irq)
		else $error("interrupt low with unmasked status set");

	// Fetch stream refusals and upper window, then the data uncached window, mirroring the checks above
	instr_above_a: assert property (
		i_req.valid && i_req.user && i_req.addr[31]
		|=> i_rsp.addr_err && !i_rsp.go && i_rsp.paddr == 32'h0000_0000 && status_r[EV_I_AERR])
		else $error("user fetch above user segment not refused");

	instr_bound_a: assert property (
		i_req.valid && !i_req.addr[31] && i_req.addr[31:12] > {1'b0, ilimit_r}
		|=> i_rsp.bound_err && !i_rsp.go && i_rsp.paddr == 32'h0000_0000 && status_r[EV_I_BERR])
		else $error("out-of-range fetch not refused");

	instr_kupper_a: assert property (
		i_req.valid && !i_req.user && i_req.addr[31:30] == 2'b11
		|=> i_rsp.go && i_rsp.paddr == {2'b00, $past(i_req.addr[29:0])})
		else $error("fetch upper window offset wrong");

	data_kuncached_a: assert property (
		d_req.valid && !d_req.user && d_req.addr[31:29] == 3'b101
		|=> d_rsp.go && d_rsp.paddr == {3'b000, $past(d_req.addr[28:0])})
		else $error("data uncached window offset wrong");

	// Idle cycles must never look like a fault; the pipeline leaves junk on the address
	instr_idle_a: assert property (
		!i_req.valid
		|=> !i_rsp.valid && !i_rsp.go && !i_rsp.addr_err && !i_rsp.bound_err && i_rsp.paddr == 32'h0000_0000)
		else $error("idle fetch slot produced a response");

	data_idle_a: assert property (
		!d_req.valid
		|=> !d_rsp.valid && !d_rsp.go && !d_rsp.addr_err && !d_rsp.bound_err && d_rsp.paddr == 32'h0000_0000)
		else $error("idle data slot produced a response");

	// Status bits record each refusal, and only refusals or a clear change them
	data_aerr_flag_a: assert property (
		d_req.valid && d_req.user && d_req.addr[31] |=> status_r[EV_D_AERR])
		else $error("data address error not recorded");

	data_berr_flag_a: assert property (
		d_req.valid && !d_req.addr[31] && d_req.addr[31:12] > {1'b0, dlimit_r} |=> status_r[EV_D_BERR])
		else $error("data bound error not recorded");

	status_hold_a: assert property (
		!(|ev) && !(reg_wr && ra == OFS_STATUS) |=> status_r == $past(status_r))
		else $error("status changed without event or clear");

	// Fault address: low word only, data side wins a tie
	fault_low_a: assert property (
		i_req.valid |=> i_rsp.fault == $past(i_req.addr[31:0]))
		else $error("fetch fault address not the low word");

	instr_fault_a: assert property (
		i_req.valid && i_req.user && i_req.addr[31] && !d_req.valid
		|=> fault_r == $past(i_req.addr[31:0]))
		else $error("fetch fault address not kept");

	// Register writes land one cycle later; read data last one cycle only
	policy_write_a: assert property (
		reg_wr && ra == OFS_CACHE_POLICY_SELECT |=> cache_policy_select_r == $past(reg_wdata[23:0]))
		else $error("cache policy write lost");

	limit_write_a: assert property (
		reg_wr && ra == OFS_ILIMIT |=> ilimit_r == $past(reg_wdata[30:12]))
		else $error("fetch limit write lost");

	base_write_a: assert property (
		reg_wr && ra == OFS_DATA_BASE_OFFSET |=> data_base_offset_r == $past(reg_wdata[31:12]))
		else $error("data base write lost");

	rdata_idle_a: assert property (
		!reg_rd |=> reg_rdata == 32'h0000_0000)
		else $error("read data shown without a read");

endmodule : bbm_mapper

// ==== sim/bbm_core_model.sv ====
// Pipeline-side model: puts one bench-chosen request per cycle on a stream.
// Assumes the bench hands over a request and stream select at a rising edge.
`timescale 1ns/1ps
module bbm_core_model import bbm_pkg::*; (
	input wire logic clock,
	input wire logic rst_n,
	input bbm_req_t cmd,
	input wire logic sel,
	output bbm_req_t i_req,
	output bbm_req_t d_req
);
	// Idle streams show inverted fields so a stale request can never match
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			i_req <= '0;
			d_req <= '0;
		end else begin
			i_req <= (cmd.valid && !sel) ? cmd : bbm_req_t'{1'b0, ~i_req.user, ~i_req.addr};
			d_req <= (cmd.valid && sel) ? cmd : bbm_req_t'{1'b0, ~d_req.user, ~d_req.addr};
		end
	end
endmodule : bbm_core_model

// ==== sim/bbm_mapper_test.sv ====
// Self-checking bench for the address mapper: windows, bounds, policy, faults.
// Assumes the core model adds one cycle ahead of the mapper's own cycle.
`timescale 1ns/1ps
module bbm_mapper_test import bbm_pkg::*;;
	logic clock, rst_n, reg_wr, reg_rd, sel, irq;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata;
	bbm_req_t cmd, i_req, d_req;
	bbm_rsp_t i_rsp, d_rsp;
	logic [19:0] base [2];
	logic [18:0] lim [2];
	logic [23:0] cal;
	int n_errors = 0;
	int compares = 0;
	int cycles = 0;

	bbm_core_model core (.clock(clock), .rst_n(rst_n), .cmd(cmd), .sel(sel), .i_req(i_req), .d_req(d_req));
	bbm_mapper #(.REG_AW(8)) dut (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .i_req(i_req), .d_req(d_req),
		.i_rsp(i_rsp), .d_rsp(d_rsp), .irq(irq));

	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	task automatic conclude;
		if (n_errors == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : conclude

	// Hang guard: the whole run needs well under a thousand cycles
	always @(posedge clock) begin
		cycles++;
		if (cycles == 4000) begin
			n_errors++;
			conclude;
		end
	end

	task automatic chk(input logic [70:0] g, input logic [70:0] e);
		compares++;
		if (g !== e) begin
			n_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask : wr

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1;
		chk({39'h0, reg_rdata}, {39'h0, e});
	endtask : rd

	task automatic setp(input logic s, input logic [19:0] b, input logic [18:0] l);
		base[s] = b;
		lim[s] = l;
		wr(s ? OFS_DATA_BASE_OFFSET : OFS_INSTR_BASE_OFFSET, {b, 12'h000});
		wr(s ? OFS_DLIMIT : OFS_ILIMIT, {1'b0, l, 12'h000});
	endtask : setp

	// One translation; every response field is judged, refused accesses too
	task automatic xl(input logic s, input logic u, input logic [63:0] a);
		bbm_rsp_t e, r;
		e = '0;
		e.valid = 1'b1;
		e.fault = a[31:0];
		e.cache_policy_select = cal[3*a[31:29] +: 3];
		e.addr_err = u && a[31];
		e.bound_err = !a[31] && (a[31:12] > {1'b0, lim[s]});
		e.go = !e.addr_err && !e.bound_err;
		if (e.go)
			e.paddr = a[31] ? a[31:0] - (a[31:30] == 2'b11 ? KUPPER_OFS : (a[29] ? KUNCACHED_OFS : KCACHED_OFS))
				: {a[31:12] + base[s], a[11:0]};
		@(posedge clock);
		cmd <= '{1'b1, u, a};
		sel <= s;
		@(posedge clock);
		cmd.valid <= 1'b0;
		@(posedge clock);
		#1;
		r = s ? d_rsp : i_rsp;
		chk(r, e);
	endtask : xl

	task automatic t_kernel;
		rd(OFS_CACHE_POLICY_SELECT, {8'h00, CACHE_POLICY_SELECT_RST});
		xl(1'b0, 1'b0, 64'h0000_0000_8000_1234);
		xl(1'b0, 1'b0, 64'h0000_0000_A000_0008);
		xl(1'b1, 1'b0, 64'hFFFF_FFFF_BFFF_FFFC);
		xl(1'b1, 1'b0, 64'h1234_5678_C000_0010);
		xl(1'b0, 1'b0, 64'h0000_0000_FFFF_F000);
	endtask : t_kernel

	// Equal page is in range, the next page is not; base sum wraps
	task automatic t_bounds;
		setp(1'b0, 20'hFFFF0, 19'h00010);
		rd(OFS_ILIMIT, {1'b0, lim[0], 12'h000});
		xl(1'b0, 1'b1, 64'h0000_0000_0001_0ABC);
		xl(1'b0, 1'b1, 64'h0000_0000_0001_1000);
		xl(1'b0, 1'b0, 64'h0000_0000_0001_1000);
		xl(1'b0, 1'b0, 64'h0000_0000_0000_0FFF);
	endtask : t_bounds

	task automatic t_split;
		setp(1'b1, 20'h00100, 19'h00008);
		xl(1'b1, 1'b1, 64'h0000_0000_0000_8ABC);
		xl(1'b1, 1'b1, 64'h0000_0000_0001_0ABC);
		xl(1'b0, 1'b1, 64'h0000_0000_0000_8ABC);
	endtask : t_split

	// Bits 1 and 3 are already set but masked off
	task automatic t_irq;
		chk({70'h0, irq}, 71'h0);
		wr(OFS_MASK, 32'h0000_0004);
		xl(1'b0, 1'b1, 64'hFFFF_0000_9000_0000);
		xl(1'b1, 1'b1, 64'h0000_0000_8000_0040);
		chk({70'h0, irq}, 71'h1);
		rd(OFS_FAULT, 32'h8000_0040);
		rd(OFS_STATUS, 32'h0000_000F);
		wr(OFS_STATUS, 32'h0000_0004);
		@(posedge clock);
		#1;
		chk({70'h0, irq}, 71'h0);
		rd(OFS_STATUS, 32'h0000_000B);
		rd(8'hFC, 32'h0000_0000);
	endtask : t_irq

	// Field n holds code n, so a wrong field pick shows at once
	task automatic t_policy;
		cal = 24'hFAC688;
		wr(OFS_CACHE_POLICY_SELECT, {8'h00, cal});
		setp(1'b1, 20'h00000, 19'h7FFFF);
		for (int k = 0; k < 8; k++)
			xl(1'b1, 1'b0, {32'h0000_0000, k[2:0], 29'h0000_0ABC});
		xl(1'b1, 1'b1, 64'h0000_0000_7FFF_F123);
	endtask : t_policy

	initial begin
		rst_n = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = '0;
		reg_wdata = '0;
		cmd = '0;
		sel = 1'b0;
		cal = CACHE_POLICY_SELECT_RST;
		base[0] = '0;
		base[1] = '0;
		lim[0] = '0;
		lim[1] = '0;
		repeat (20) @(posedge clock);
		rst_n <= 1'b1;
		t_kernel;
		t_bounds;
		t_split;
		t_irq;
		t_policy;
		conclude;
	end
endmodule : bbm_mapper_test
